/* File: core/etf_codec.sv */
// receive side of the transmit request framer: unescapes, checks and decodes frames
`timescale 1ns/1ps
`default_nettype none
`include "etf_params.svh"
module etf_codec (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // serial api byte stream from the host side
   input wire logic in_valid_i,
   input wire logic [7:0] in_data_i,
   output logic in_ready_o,
   // configuration
   input wire logic [1:0] frame_escape_mode_setting_i,
   input wire logic [7:0] max_hop_count_setting_i,
   input wire logic [15:0] max_payload_size_query_i,
   input wire logic [7:0] default_dest_endpoint_i,
   input wire logic [7:0] default_src_endpoint_i,
   input wire logic [15:0] default_cluster_setting_i,
   // payload stream to the transmit logic
   output logic pay_valid_o,
   output logic [7:0] pay_data_o,
   output logic pay_last_o,
   input wire logic pay_ready_i,
   // decoded frame
   output logic frame_done_o,
   output logic frame_ok_o,
   output logic [4:0] err_o,
   output logic resp_req_o,
   output logic [7:0] frame_type_o,
   output logic [7:0] frame_id_o,
   output logic [63:0] dest_addr_o,
   output logic broadcast_o,
   output logic [7:0] src_ep_o,
   output logic [7:0] dst_ep_o,
   output logic [15:0] cluster_o,
   output logic [15:0] profile_o,
   output logic [7:0] radius_o,
   output logic ack_dis_o,
   output logic route_disc_dis_o,
   output logic nack_en_o,
   output logic trace_en_o,
   output logic [1:0] method_o
);
   etf_pkg::etf_core_t q;
   etf_pkg::etf_core_t d;
   logic acc;
   logic esc_mode;
   logic restart;
   logic proc;
   logic [7:0] b;
   logic is_chk;
   logic fin;
   logic known;
   logic [15:0] pay_off;
   logic [15:0] hdr_len;
   logic [7:0] tot;
   logic push;
   logic fifo_rdy;
   logic [8:0] fifo_out;

   // ----------------------------------------
   // byte intake and unescaping
   // ----------------------------------------
   // one ready for every byte keeps the handshake simple; it only drops when the buffer fills
   assign in_ready_o = fifo_rdy;
   assign acc = in_valid_i & in_ready_o;
   // a 0x7D only arms the escape in escaping mode; in plain mode it is ordinary data
   assign esc_mode = (frame_escape_mode_setting_i == `ETF_MODE_ESC);
   // a bare delimiter always means frame start when escaping is on; in plain mode only while idle
   assign restart = acc & (in_data_i == `ETF_DELIM) & (esc_mode | (q.st == etf_pkg::ETF_IDLE));
   assign proc = acc & !restart & (q.st != etf_pkg::ETF_IDLE)
                 & !(esc_mode & !q.esc & (in_data_i == `ETF_ESC));
   assign b = q.esc ? (in_data_i ^ `ETF_XOR) : in_data_i;

   // ----------------------------------------
   // frame layout by type
   // ----------------------------------------
   assign known = (q.ftype == `ETF_TYPE_TX) | (q.ftype == `ETF_TYPE_EXP);
   assign pay_off = (q.ftype == `ETF_TYPE_EXP) ? `ETF_OFF_PAY : `ETF_TX_OFF_PAY;
   assign hdr_len = pay_off - `ETF_OFF_TYPE;
   assign is_chk = (q.pos == q.len + `ETF_OFF_TYPE);
   assign fin = proc & (q.st == etf_pkg::ETF_BODY) & is_chk;
   assign tot = q.sum + b;
   // payload leaves before the checksum is known; a bad frame is only flagged at its end
   assign push = proc & (q.st == etf_pkg::ETF_BODY) & !is_chk & known & (q.pos >= pay_off);

   always_comb
   begin
      d = q;
      d.done = 1'b0;
      if (restart)
      begin
         d.st = etf_pkg::ETF_LEN_HI;
         d.esc = 1'b0;
      end
      else if (acc & esc_mode & !q.esc & (in_data_i == `ETF_ESC) & (q.st != etf_pkg::ETF_IDLE))
      begin
         d.esc = 1'b1;
      end
      if (proc)
      begin
         d.esc = 1'b0;
         unique case (q.st)
            etf_pkg::ETF_LEN_HI:
            begin
               d.len[15:8] = b;
               d.st = etf_pkg::ETF_LEN_LO;
            end
            etf_pkg::ETF_LEN_LO:
            begin
               d.len[7:0] = b;
               d.pos = `ETF_OFF_TYPE;
               d.sum = 8'h00;
               d.ftype = 8'h00;
               d.fid = 8'h00;
               d.profile = 16'h0000;
               d.radius = 8'h00;
               d.opts = 8'h00;
               d.st = etf_pkg::ETF_BODY;
            end
            etf_pkg::ETF_BODY:
            begin
               if (!is_chk)
               begin
                  d.sum = q.sum + b;
                  d.pos = q.pos + 16'h0001;
                  if (q.pos == `ETF_OFF_TYPE)
                     d.ftype = b;
                  if (q.pos == `ETF_OFF_FID)
                     d.fid = b;
                  if ((q.pos >= `ETF_OFF_DEST_LO) && (q.pos <= `ETF_OFF_DEST_HI))
                     d.dest = {q.dest[55:0], b};
                  if (q.ftype == `ETF_TYPE_TX)
                  begin
                     if (q.pos == `ETF_TX_OFF_RAD)
                        d.radius = b;
                     if (q.pos == `ETF_TX_OFF_OPT)
                        d.opts = b;
                  end
                  if (q.ftype == `ETF_TYPE_EXP)
                  begin
                     if (q.pos == `ETF_OFF_SRC_EP)
                        d.src_ep = b;
                     if (q.pos == `ETF_OFF_DST_EP)
                        d.dst_ep = b;
                     if (q.pos == `ETF_OFF_CLU_HI)
                        d.cluster[15:8] = b;
                     if (q.pos == `ETF_OFF_CLU_LO)
                        d.cluster[7:0] = b;
                     if (q.pos == `ETF_OFF_PRO_HI)
                        d.profile[15:8] = b;
                     if (q.pos == `ETF_OFF_PRO_LO)
                        d.profile[7:0] = b;
                     if (q.pos == `ETF_OFF_RAD)
                        d.radius = b;
                     if (q.pos == `ETF_OFF_OPT)
                        d.opts = b;
                  end
               end
               else
               begin
                  d.st = etf_pkg::ETF_IDLE;
                  d.done = 1'b1;
                  d.err = 5'h00;
                  d.err[`ETF_ERR_CHK] = (tot != `ETF_CHK_TOTAL);
                  d.err[`ETF_ERR_TYPE] = !known;
                  d.err[`ETF_ERR_LEN] = known & (q.len < hdr_len);
                  d.err[`ETF_ERR_METHOD] = known & (q.opts[7:6] == 2'b00);
                  d.err[`ETF_ERR_SIZE] = known & (q.len >= hdr_len)
                                         & ((q.len - hdr_len) > max_payload_size_query_i);
                  d.ok = (d.err == 5'h00);
                  d.resp = known & (q.fid != 8'h00);
                  if (q.ftype == `ETF_TYPE_TX)
                  begin
                     // plain requests fall back to the configured addressing
                     d.src_ep = default_src_endpoint_i;
                     d.dst_ep = default_dest_endpoint_i;
                     d.cluster = default_cluster_setting_i;
                  end
                  if ((q.radius == 8'h00) || (q.radius > max_hop_count_setting_i))
                     d.radius = max_hop_count_setting_i;
               end
            end
            etf_pkg::ETF_IDLE:
            begin
               d.st = etf_pkg::ETF_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------
   // payload buffer
   // ----------------------------------------
   // a stalled drain side holds in_ready_o low, so the host waits instead of losing bytes
   etf_fifo #(
      .W(`ETF_FIFO_WIDTH),
      .D(`ETF_FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_data_i({(q.pos == q.len + 16'h0002), b}),
      .in_ready_o(fifo_rdy),
      .out_valid_o(pay_valid_o),
      .out_data_o(fifo_out),
      .out_ready_i(pay_ready_i)
   );
   assign pay_data_o = fifo_out[7:0];
   assign pay_last_o = fifo_out[8];

   // ----------------------------------------
   // decoded outputs
   // ----------------------------------------
   assign frame_done_o = q.done;
   assign frame_ok_o = q.ok;
   assign err_o = q.err;
   assign resp_req_o = q.resp;
   assign frame_type_o = q.ftype;
   assign frame_id_o = q.fid;
   assign dest_addr_o = q.dest;
   assign broadcast_o = (q.dest == `ETF_BCAST);
   assign src_ep_o = q.src_ep;
   assign dst_ep_o = q.dst_ep;
   assign cluster_o = q.cluster;
   assign profile_o = q.profile;
   assign radius_o = q.radius;
   assign ack_dis_o = q.opts[0];
   assign route_disc_dis_o = q.opts[1];
   assign nack_en_o = q.opts[2];
   assign trace_en_o = q.opts[3];
   assign method_o = q.opts[7:6];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // decoded fields move while a frame is parsed, so the checks look at them on frame_done_o, except src_ep_field_a, which reads src_ep right after its byte
   chk_sum_check_a: assert property (fin |=> err_o[0] == $past(tot != 8'hFF))
      else $error("checksum verdict does not match byte sum");
   esc_byte_undo_a: assert property (q.esc && proc && q.st == etf_pkg::ETF_BODY
      && !is_chk
      |=> q.sum == $past(q.sum + (in_data_i ^ 8'h20)))
      else $error("escaped byte not restored before the checksum");
   esc_prefix_held_a: assert property (esc_mode && acc && !q.esc && in_data_i == 8'h7D
      && q.st != etf_pkg::ETF_IDLE |=> q.esc)
      else $error("escape prefix not remembered");
   plain_no_esc_a: assert property (!esc_mode && q.st != etf_pkg::ETF_LEN_HI |-> !q.esc)
      else $error("escape state set while escaping is off");
   tx_pay_start_a: assert property (push && q.ftype == 8'h10 |-> q.pos >= 16'h0011)
      else $error("plain payload starts before offset 17");
   exp_type_seen_a: assert property (fin && q.ftype == 8'h11
      |=> !err_o[2] ##0 frame_type_o == 8'h11)
      else $error("explicit frame not recognised");
   zero_id_silent_a: assert property (frame_done_o && frame_id_o == 8'h00 |-> !resp_req_o)
      else $error("response requested for zero frame id");
   resp_echo_a: assert property (fin && known && q.fid != 8'h00 |=> resp_req_o)
      else $error("nonzero frame id did not request a response");
   src_ep_field_a: assert property (proc && q.st == etf_pkg::ETF_BODY && !is_chk
      && q.ftype == 8'h11 && q.pos == 16'h000F |=> q.src_ep == $past(b))
      else $error("source endpoint not taken from offset 15");
   tx_defaults_a: assert property (frame_done_o && frame_type_o == 8'h10
      |-> src_ep_o == $past(default_src_endpoint_i)
      && cluster_o == $past(default_cluster_setting_i))
      else $error("plain frame did not use configured defaults");
   radius_clamp_a: assert property (frame_done_o |-> radius_o != 8'h00
      ? radius_o <= $past(max_hop_count_setting_i)
      : $past(max_hop_count_setting_i) == 8'h00)
      else $error("radius not clamped to hop limit");
   method_invalid_a: assert property (frame_done_o && method_o == 2'b00 |-> !frame_ok_o)
      else $error("invalid delivery method accepted");
   exp_pay_start_a: assert property (push && q.ftype == 8'h11 |-> q.pos >= 16'h0017)
      else $error("explicit payload starts before offset 23");
   size_limit_a: assert property (fin && known && q.len >= hdr_len
      && (q.len - hdr_len) > max_payload_size_query_i |=> err_o[4])
      else $error("oversized payload not flagged");
   idle_wait_delim_a: assert property (q.st == etf_pkg::ETF_IDLE && acc
      && in_data_i != 8'h7E |=> q.st == etf_pkg::ETF_IDLE)
      else $error("frame started without delimiter");
   len_short_a: assert property (fin && known && q.len < hdr_len |=> err_o[1])
      else $error("frame shorter than its header not flagged");
   done_pulse_a: assert property (frame_done_o |=> !frame_done_o)
      else $error("frame done held for more than one cycle");

   good_exp_c: cover property (frame_done_o && frame_ok_o && frame_type_o == 8'h11);
   good_tx_esc_c: cover property (frame_done_o && frame_ok_o && esc_mode && frame_type_o == 8'h10);
   bad_chk_c: cover property (frame_done_o && err_o[0]);
   stall_c: cover property (in_valid_i && !in_ready_o);
   good_bcast_c: cover property (frame_done_o && frame_ok_o && broadcast_o);
endmodule
`default_nettype wire

/* File: core/etf_params.svh */
// constants for the explicit transmit frame codec
`ifndef ETF_PARAMS_SVH
`define ETF_PARAMS_SVH

// ----------------------------------------
// framing bytes
// ----------------------------------------
`define ETF_DELIM 8'h7E
`define ETF_ESC 8'h7D
`define ETF_XOR 8'h20
`define ETF_CHK_TOTAL 8'hFF
`define ETF_MODE_ESC 2'h2
`define ETF_TYPE_TX 8'h10
`define ETF_TYPE_EXP 8'h11
`define ETF_BCAST 64'h0000_0000_0000_FFFF

// ----------------------------------------
// byte offsets within a frame
// ----------------------------------------
`define ETF_OFF_TYPE 16'h0003
`define ETF_OFF_FID 16'h0004
`define ETF_OFF_DEST_LO 16'h0005
`define ETF_OFF_DEST_HI 16'h000C
`define ETF_OFF_SRC_EP 16'h000F
`define ETF_OFF_DST_EP 16'h0010
`define ETF_OFF_CLU_HI 16'h0011
`define ETF_OFF_CLU_LO 16'h0012
`define ETF_OFF_PRO_HI 16'h0013
`define ETF_OFF_PRO_LO 16'h0014
`define ETF_OFF_RAD 16'h0015
`define ETF_OFF_OPT 16'h0016
`define ETF_OFF_PAY 16'h0017
`define ETF_TX_OFF_RAD 16'h000F
`define ETF_TX_OFF_OPT 16'h0010
`define ETF_TX_OFF_PAY 16'h0011

// ----------------------------------------
// error bit positions and buffer shape
// ----------------------------------------
`define ETF_ERR_CHK 0
`define ETF_ERR_LEN 1
`define ETF_ERR_TYPE 2
`define ETF_ERR_METHOD 3
`define ETF_ERR_SIZE 4
`define ETF_FIFO_DEPTH 4
`define ETF_FIFO_WIDTH 9

`endif

/* File: core/etf_pkg.sv */
// types for the explicit transmit frame codec
package etf_pkg;

   typedef enum logic [1:0] {
      ETF_IDLE = 2'b00,
      ETF_LEN_HI = 2'b01,
      ETF_LEN_LO = 2'b10,
      ETF_BODY = 2'b11
   } etf_state_t;

   typedef struct packed {
      etf_state_t st;
      logic esc;
      logic [15:0] len;
      logic [15:0] pos;
      logic [7:0] sum;
      logic [7:0] ftype;
      logic [7:0] fid;
      logic [63:0] dest;
      logic [7:0] src_ep;
      logic [7:0] dst_ep;
      logic [15:0] cluster;
      logic [15:0] profile;
      logic [7:0] radius;
      logic [7:0] opts;
      logic done;
      logic ok;
      logic resp;
      logic [4:0] err;
   } etf_core_t;

endpackage

/* File: core/etf_fifo.sv */
// small payload buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module etf_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   localparam logic [AW-1:0] LAST = AW'(D - 1);
   localparam logic [CW-1:0] FULL = CW'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } etf_fifo_t;

   etf_fifo_t q;
   etf_fifo_t d;
   logic push;
   logic pop;

   assign in_ready_o = (q.cnt != FULL);
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o = q.mem[q.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = in_data_i;
         d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
      end
      if (pop)
      begin
         d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
      end
      d.cnt = q.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   fifo_no_overflow_a: assert property (q.cnt == FULL |-> !in_ready_o)
      else $error("fifo accepts data while full");
   fifo_count_step_a: assert property (push && !pop |=> q.cnt == $past(q.cnt) + 1'b1)
      else $error("fifo count did not rise on a push");
endmodule
`default_nettype wire

/* File: sim/etf_host.sv */
// host model: frames, checksums and escapes bytes onto the serial api stream
`timescale 1ns/1ps
`default_nettype none
`include "etf_params.svh"
module etf_host (
   // clock
   input wire logic core_clk_i,
   // byte stream to the codec
   output logic valid_o,
   output logic [7:0] data_o,
   input wire logic ready_i
);
   initial
   begin
      valid_o = 1'b0;
      data_o = 8'h00;
   end
   // hold valid and data until ready is seen at an edge
   task automatic put(input logic [7:0] b);
      valid_o <= 1'b1;
      data_o <= b;
      do @(posedge core_clk_i); while (ready_i !== 1'b1);
   endtask
   task automatic put_esc(input logic [7:0] b, input logic esc);
      if (esc && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13))
      begin
         put(`ETF_ESC);
         put(b ^ `ETF_XOR);
      end
      else
         put(b);
   endtask
   // bad flips checksum bits to provoke a checksum error
   task automatic send_frame(input logic [7:0] body[$], input logic [1:0] mode,
                             input logic [7:0] bad);
      logic [7:0] sum;
      logic esc;
      logic [15:0] len;
      sum = 8'h00;
      esc = (mode == `ETF_MODE_ESC);
      len = 16'(body.size());
      foreach (body[i]) sum = sum + body[i];
      @(posedge core_clk_i);
      put(`ETF_DELIM);
      put_esc(len[15:8], esc);
      put_esc(len[7:0], esc);
      foreach (body[i]) put_esc(body[i], esc);
      put_esc((`ETF_CHK_TOTAL - sum) ^ bad, esc);
      valid_o <= 1'b0;
      // released line shows the inverse rather than a stale byte
      data_o <= ~data_o;
   endtask
endmodule
`default_nettype wire

/* File: sim/test_etf_codec.sv */
// self-checking testbench for the explicit transmit frame codec
`timescale 1ns/1ps
`default_nettype none
module test_etf_codec;
   typedef logic [7:0] etf_bq_t[$];
   logic clk, rst, in_valid, in_ready, pay_valid, pay_last, pay_ready;
   logic done, ok, resp, bcast, ackd, rdd, nack, trace;
   logic [7:0] in_data, pay_data, ftype, fid, sep, dep, rad, hop;
   logic [1:0] mode, meth;
   logic [4:0] err;
   logic [15:0] clu, pro, maxp, dcl;
   logic [63:0] dest;
   logic [7:0] got[$];
   int err_total, total_checks, last_idx, cyc;
   logic seen_full;
   etf_bq_t pl;
   etf_host u_host (.core_clk_i(clk), .valid_o(in_valid), .data_o(in_data), .ready_i(in_ready));
   etf_codec u_dut (.core_clk_i(clk), .rst_i(rst), .in_valid_i(in_valid), .in_data_i(in_data),
      .in_ready_o(in_ready), .frame_escape_mode_setting_i(mode),
      .max_hop_count_setting_i(hop), .max_payload_size_query_i(maxp),
      .default_dest_endpoint_i(8'hA1), .default_src_endpoint_i(8'hB2),
      .default_cluster_setting_i(dcl), .pay_valid_o(pay_valid), .pay_data_o(pay_data),
      .pay_last_o(pay_last), .pay_ready_i(pay_ready), .frame_done_o(done), .frame_ok_o(ok),
      .err_o(err), .resp_req_o(resp), .frame_type_o(ftype), .frame_id_o(fid),
      .dest_addr_o(dest), .broadcast_o(bcast), .src_ep_o(sep), .dst_ep_o(dep),
      .cluster_o(clu), .profile_o(pro), .radius_o(rad), .ack_dis_o(ackd),
      .route_disc_dis_o(rdd), .nack_en_o(nack), .trace_en_o(trace), .method_o(meth));
   // ----------------------------------------
   // clock, drain with stalls, watchdog
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // drain takes one slot in four, so the buffer fills and refuses
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      pay_ready <= (cyc[1:0] == 2'b00);
      if (in_ready === 1'b0)
         seen_full <= 1'b1;
      if (pay_valid === 1'b1 && pay_ready === 1'b1)
      begin
         got.push_back(pay_data);
         if (pay_last === 1'b1)
            last_idx <= got.size();
      end
   end
   initial
   begin
      #(8 * 20000);
      err_total = err_total + 1;
      final_report();
   end
   // ----------------------------------------
   // checking tasks
   // ----------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // body of a type 0x10 or 0x11 frame with payload pl appended, destination most significant byte first
   function automatic etf_bq_t body(input logic [7:0] t, f, input logic [63:0] da,
      input logic [7:0] se, de, input logic [15:0] cl, pr, input logic [7:0] ra, op);
      etf_bq_t q;
      q = {t, f};
      for (int i = 7; i >= 0; i--) q.push_back(da[i*8 +: 8]);
      q.push_back(8'hFF);
      q.push_back(8'hFE);
      if (t == 8'h11)
         q = {q, se, de, cl[15:8], cl[7:0], pr[15:8], pr[7:0]};
      q = {q, ra, op, pl};
      return q;
   endfunction
   task automatic run(input logic [7:0] t, f, input logic [63:0] da, input logic [7:0] se, de,
      input logic [15:0] cl, pr, input logic [7:0] ra, op, erad, input logic [4:0] er,
      input logic rs, input logic [7:0] bad);
      int n;
      got.delete();
      last_idx = 0;
      // a setting changed just before the call must settle before the host reads it
      @(posedge clk);
      u_host.send_frame(body(t, f, da, se, de, cl, pr, ra, op), mode, bad);
      // frame_done_o stands only in the cycle after the checksum byte is taken
      #1;
      n = 0;
      while (done !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(done, 1'b1);
      check(err, er);
      check(ok, er == 5'h00);
      check(resp, rs);
      if (t == 8'h12)
         return;
      check(ftype, t);
      check(fid, f);
      check(dest, da);
      check(bcast, da == 64'h0000_0000_0000_FFFF);
      check(sep, t == 8'h11 ? se : 8'hB2);
      check(dep, t == 8'h11 ? de : 8'hA1);
      check(clu, t == 8'h11 ? cl : 16'hC3D4);
      check(pro, t == 8'h11 ? pr : 16'h0000);
      check(rad, erad);
      check({trace, nack, rdd, ackd}, op[3:0]);
      check(meth, op[7:6]);
      n = 0;
      while (got.size() < pl.size() && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      check(got.size(), pl.size());
      foreach (pl[i]) check(got[i], pl[i]);
      check(last_idx, pl.size());
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      mode = 2'h1;
      hop = 8'h05;
      maxp = 16'h0008;
      dcl = 16'hC3D4;
      cyc = 0;
      err_total = 0;
      total_checks = 0;
      seen_full = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check({done, ok, err, resp, pay_valid, in_ready}, 10'h001);
      // plain request without and with escaping; payload at the size limit
      pl = {8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61, 8'h30, 8'h41};
      for (int m = 1; m <= 2; m++)
      begin
         mode <= 2'(m);
         run(8'h10, 8'h01, 64'h0013_A200_400A_0127, 0, 0, 0, 0, 8'h00, 8'h40, 8'h05,
             5'h00, 1'b1, 8'h00);
      end
      // explicit frame with delivery method 00
      pl = {8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
      run(8'h11, 8'h01, 64'h0013_A200_0123_8400, 8'hE8, 8'hE8, 16'h0011, 16'hC105, 8'h00,
          8'h00, 8'h05, 5'h08, 1'b1, 8'h00);
      // escaped broadcast, radius above limit, every option bit, no response
      pl = {8'h7E, 8'h7D, 8'h11, 8'h13};
      run(8'h11, 8'h00, 64'h0000_0000_0000_FFFF, 8'h13, 8'h7E, 16'h7D11, 16'h1300, 8'h09,
          8'hCF, 8'h05, 5'h00, 1'b0, 8'h00);
      mode <= 2'h1;
      pl = {8'h01};
      run(8'h11, 8'h07, 64'h0000_0000_0000_0042, 8'h01, 8'h02, 16'h0304, 16'h0506, 8'h03,
          8'h80, 8'h03, 5'h00, 1'b1, 8'h00);
      // a raised hop limit must now be the radius picked for a zero request
      hop <= 8'h0A;
      run(8'h11, 8'h07, 64'h0000_0000_0000_0042, 8'h01, 8'h02, 16'h0304, 16'h0506, 8'h00,
          8'h40, 8'h0A, 5'h01, 1'b1, 8'h5A);
      pl = {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
      run(8'h11, 8'h02, 64'h0000_0000_0000_0042, 8'h01, 8'h02, 16'h0304, 16'h0506, 8'h00,
          8'hC0, 8'h0A, 5'h10, 1'b1, 8'h00);
      pl = {};
      run(8'h12, 8'h02, 64'h0000_0000_0000_0042, 0, 0, 0, 0, 8'h00, 8'h40, 8'h05, 5'h04,
          1'b0, 8'h00);
      check(got.size(), 0);
      check(seen_full, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire
